/* File: bench/cms_bus_node.sv */
`timescale 1ns/1ps

// Stands in for the other nodes; one sampled bit per call.
module cms_bus_node (
    input wire logic clk, // Controller clock.
    output cms_pkg::cms_bit_s bus_bit, // Bit view.
    output cms_pkg::cms_field_s bus_field // Field markers.
);
    // Both levels idle recessive, since a released bus floats high.
    initial begin
        bus_bit = 8'h60;
        bus_field = 7'h00;
    end

    task automatic step(input logic [7:0] b, input logic [6:0] f);
        @(posedge clk) #1;
        bus_bit = b;
        bus_field = f;
        @(posedge clk) #1;
        bus_bit = 8'h60;
        bus_field = 7'h00;
    endtask
endmodule

/* File: bench/cms_msg_status_props.sv */
`timescale 1ns/1ps

module cms_msg_status_props #(
    parameter int NOBJ = cms_pkg::NUM_OBJ
) (
    input wire logic clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic [7:0] sfr_addr, // Address.
    input wire logic sfr_wr, // Write strobe.
    input wire logic [7:0] sfr_rdata, // Read data.
    input wire logic [cms_pkg::IDX_W-1:0] page_idx, // Object page.
    input wire logic [NOBJ-1:0] tx_enable, // Transmit enables.
    input wire logic tx_ready, // Ready to send.
    input wire logic tx_sel_valid, // Transmit pick valid.
    input wire logic [cms_pkg::IDX_W-1:0] tx_sel_idx, // Transmit pick.
    input wire logic rx_done, // Reception done.
    input wire logic rx_hit_valid, // Receive hit valid.
    input wire logic [cms_pkg::IDX_W-1:0] rx_hit_idx, // Receive hit.
    input wire cms_pkg::cms_bit_s bus_bit, // Bus bit view.
    input wire cms_pkg::cms_field_s bus_field, // Field markers.
    input wire logic arb_lost // Arbitration lost.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff rst;

    // The status byte is only visible through the read port, so the page must stay put.
    sequence s_hold;
        sfr_addr == cms_pkg::ADDR_STATUS && !sfr_wr && $stable(page_idx);
    endsequence
    sequence s_form;
        bus_bit.tick && !bus_bit.rx_level && bus_field.at_eof && !bus_bit.tx_active && !rx_hit_valid
        && sfr_addr == cms_pkg::ADDR_STATUS && page_idx < 4'he;
    endsequence
    sequence s_rx;
        rx_done && rx_hit_valid && rx_hit_idx == page_idx && sfr_addr == cms_pkg::ADDR_STATUS;
    endsequence

    property p_tx_low;
        tx_ready && |tx_enable |-> tx_sel_valid && tx_enable[tx_sel_idx] && (tx_enable << (NOBJ - tx_sel_idx)) == '0;
    endproperty
    property p_tx_off;
        !tx_ready |-> !tx_sel_valid;
    endproperty
    property p_arb;
        bus_bit.tick && bus_bit.tx_active && bus_bit.in_arb && bus_bit.tx_level && !bus_bit.rx_level |=> arb_lost;
    endproperty
    property p_arb_only;
        arb_lost |-> $past(bus_bit.tick) && $past(bus_bit.in_arb) && $past(bus_bit.tx_level) && !$past(bus_bit.rx_level);
    endproperty
    property p_mask2;
        sfr_addr == cms_pkg::ADDR_MASK2 |=> sfr_rdata[4:0] == 5'h00;
    endproperty
    property p_mask3;
        sfr_addr == cms_pkg::ADDR_MASK3 |=> sfr_rdata == 8'h00;
    endproperty
    property p_form;
        s_form ##1 s_hold |=> sfr_rdata[cms_pkg::BIT_FORM_ERR];
    endproperty
    property p_rx;
        s_rx ##1 s_hold |=> sfr_rdata[cms_pkg::BIT_RX_DONE];
    endproperty

    a_tx_low: assert property (p_tx_low) else $error("transmit pick is not the lowest");
    a_tx_off: assert property (p_tx_off) else $error("transmit pick while not ready");
    a_arb: assert property (p_arb) else $error("lost arbitration not reported");
    a_arb_only: assert property (p_arb_only) else $error("spurious lost arbitration");
    a_mask2: assert property (p_mask2) else $error("mask two low bits not zero");
    a_mask3: assert property (p_mask3) else $error("mask three not zero");
    a_form: assert property (p_form) else $error("form error flag missing");
    a_rx: assert property (p_rx) else $error("receive done flag missing");
endmodule

bind cms_msg_status cms_msg_status_props #(.NOBJ(NOBJ)) props_u (.*);

/* File: bench/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic [3:0] page_idx = 4'h0;
    logic [13:0] tx_enable = 14'h0000;
    logic tx_ready = 1'b0;
    logic tx_done = 1'b0;
    logic [13:0] rx_enable = 14'h0000;
    logic [13:0] rx_high_match = 14'h3fff;
    logic [41:0] obj_id_low = 42'h740;
    logic [55:0] obj_dlc = 56'h0;
    logic [2:0] rx_id_low = 3'h3;
    logic [3:0] rx_dlc = 4'h8;
    logic rx_done = 1'b0;
    logic [7:0] sfr_rdata;
    logic [3:0] tx_sel_idx, rx_hit_idx;
    logic tx_sel_valid, rx_hit_valid, arb_lost;
    cms_pkg::cms_bit_s bus_bit;
    cms_pkg::cms_field_s bus_field;
    int mismatches = 0;
    int n_compared = 0;
    // A lone recessive bit from a zero start leaves exactly the polynomial.
    localparam logic [14:0] CRC_ONE = cms_pkg::CRC_POLY;

    always #12.5 clk = ~clk;

    cms_bus_node node_u (.*);
    cms_msg_status dut_u (.*);

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
        @(posedge clk) #1;
        sfr_addr = a;
        page_idx = p;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk) #1;
        sfr_wr = 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e);
        @(posedge clk) #1;
        sfr_addr = a;
        page_idx = p;
        @(posedge clk) #1;
        chk(sfr_rdata, e);
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk) #1;
        s = 1'b1;
        @(posedge clk) #1;
        s = 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        wr(cms_pkg::ADDR_MASK3, 4'h2, 8'h5a);
        rc(cms_pkg::ADDR_MASK3, 4'h2, 8'h00);
        tx_ready = 1'b1;
        for (int i = 0; i < 14; i++) begin
            tx_enable = 14'h2000 | (14'h1 << i);
            rx_enable = tx_enable;
            #1;
            chk(8'(tx_sel_idx), 8'(i));
            chk(8'(rx_hit_idx), 8'(i));
        end
        rx_enable = 14'h000c;
        #1 chk(8'(rx_hit_idx), 8'h02);
        // Mask bits 4-0 are kept clear by software.
        wr(cms_pkg::ADDR_MASK2, 4'h2, 8'he0);
        rc(cms_pkg::ADDR_MASK2, 4'h2, 8'he0);
        chk(8'(rx_hit_idx), 8'h03);
        wr(cms_pkg::ADDR_STATUS, 4'h3, 8'h00);
        pulse(rx_done);
        rc(cms_pkg::ADDR_STATUS, 4'h3, 8'ha0);
        obj_dlc = 56'h8000;
        wr(cms_pkg::ADDR_STATUS, 4'h3, 8'h00);
        pulse(rx_done);
        rc(cms_pkg::ADDR_STATUS, 4'h3, 8'h20);
        rx_enable = 14'h0000;
        tx_enable = 14'h0006;
        wr(cms_pkg::ADDR_STATUS, 4'h1, 8'h00);
        node_u.step(8'hb8, 7'h00);
        node_u.step(8'hb4, 7'h00);
        node_u.step(8'hb2, 7'h00);
        node_u.step(8'hf4, 7'h00);
        node_u.step(8'hf0, 7'h02);
        pulse(tx_done);
        rc(cms_pkg::ADDR_STATUS, 4'h1, 8'h41);
        wr(cms_pkg::ADDR_STATUS, 4'h1, 8'h00);
        node_u.step(8'hb0, 7'h00);
        rc(cms_pkg::ADDR_STATUS, 4'h1, 8'h10);
        wr(cms_pkg::ADDR_STATUS, 4'h0, 8'h00);
        node_u.step(8'he1, 7'h00);
        repeat (5) node_u.step(8'ha1, 7'h00);
        node_u.step(8'he1, 7'h00);
        node_u.step(8'ha0, 7'h01);
        rc(cms_pkg::ADDR_STATUS, 4'h0, 8'h02);
        node_u.step(8'he1, 7'h00);
        repeat (6) node_u.step(8'ha1, 7'h00);
        rc(cms_pkg::ADDR_STATUS, 4'h0, 8'h0a);
        wr(cms_pkg::ADDR_STATUS, 4'h0, 8'h00);
        node_u.step(8'h60, 7'h60);
        for (int i = 14; i >= 0; i--) node_u.step(CRC_ONE[i] ? 8'h60 : 8'h20, 7'h50);
        node_u.step(8'h60, 7'h08);
        rc(cms_pkg::ADDR_STATUS, 4'h0, 8'h00);
        node_u.step(8'h60, 7'h60);
        repeat (15) node_u.step(8'h20, 7'h50);
        node_u.step(8'h60, 7'h08);
        rc(cms_pkg::ADDR_STATUS, 4'h0, 8'h04);
        tally_and_finish();
    end
endmodule

/* File: verilog/cms_msg_status.sv */
// Behaviour
// - Transmit done flag set when the object's transmission finishes; software clears it.
// - Among transmit-enabled objects 0 to 13, lowest index is sent first.
// - Receive done flag set when the object's reception finishes; software clears it.
// - Among objects hit by a received frame, lowest index is updated first.
// - While transmitting, sampled level differing from driven level flags a bit error.
// - Recessive sent, dominant read in arbitration is lost arbitration, no error.
// - No bit error for dominant acknowledge slot or while sending error frame.
// - CRC computed over destuffed bits from start of frame through data field.
// - Computed CRC not equal to received CRC field sets the CRC error flag.
// - Violated CRC delimiter, acknowledge delimiter or end of frame flags form error.
// - Mask bit 0 forces identifier bit match; mask bit 1 enables real comparison.
`timescale 1ns/1ps

module cms_msg_status #(
    parameter int NOBJ = cms_pkg::NUM_OBJ
) (
    input wire logic clk,                                   // Controller clock, 40 MHz.
    input wire logic rst,                                   // Synchronous reset, active high.
    input wire logic [7:0] sfr_addr,                        // Register address.
    input wire logic [7:0] sfr_wdata,                       // Register write data.
    input wire logic sfr_wr,                                // Write strobe, one cycle.
    output logic [7:0] sfr_rdata,                           // Register read data.
    input wire logic [cms_pkg::IDX_W-1:0] page_idx,         // Object seen through the registers.
    input wire logic [NOBJ-1:0] tx_enable,                  // Objects enabled for transmission.
    input wire logic tx_ready,                              // Controller ready to start a frame.
    input wire logic tx_done,                               // Pulse, transmission finished.
    output logic tx_sel_valid,                              // A transmit object is chosen.
    output logic [cms_pkg::IDX_W-1:0] tx_sel_idx,           // Chosen transmit object.
    input wire logic [NOBJ-1:0] rx_enable,                  // Objects enabled for reception.
    input wire logic [NOBJ-1:0] rx_high_match,              // Upper identifier bits match.
    input wire logic [NOBJ*3-1:0] obj_id_low,               // Per-object identifier bits 2-0.
    input wire logic [NOBJ*4-1:0] obj_dlc,                  // Per-object configured length.
    input wire logic [2:0] rx_id_low,                       // Received identifier bits 2-0.
    input wire logic [3:0] rx_dlc,                          // Received data length code.
    input wire logic rx_done,                               // Pulse, reception finished.
    output logic rx_hit_valid,                              // Some object accepts the frame.
    output logic [cms_pkg::IDX_W-1:0] rx_hit_idx,           // Object updated by the frame.
    input wire cms_pkg::cms_bit_s bus_bit,                  // Bit-level bus view.
    input wire cms_pkg::cms_field_s bus_field,              // Frame field markers.
    output logic arb_lost                                   // Pulse, arbitration lost.
);

    localparam int IW = cms_pkg::IDX_W;

    logic [7:0] status_reg [NOBJ];
    logic [cms_pkg::MASK_W-1:0] mask_reg [NOBJ];
    logic [IW-1:0] tx_obj_reg;
    logic [14:0] crc_reg;
    logic [14:0] crc_rx_reg;
    logic [2:0] same_cnt_reg;
    logic last_level_reg;
    logic ack_seen_reg;
    logic arb_lost_reg;
    logic [7:0] rdata_reg;

    logic [NOBJ-1:0] rx_hit;
    logic [IW-1:0] err_obj;
    logic page_ok;
    logic wr_status;
    logic wr_mask;
    logic ev_bit_err;
    logic ev_stuff_err;
    logic ev_crc_err;
    logic ev_form_err;
    logic ev_ack_err;
    logic ev_len_warn;
    logic [7:0] err_set;
    logic [14:0] crc_next;
    logic crc_fb;
    logic [3:0] hit_dlc;

    function automatic logic [IW:0] lowest(input logic [NOBJ-1:0] req);
        logic [IW:0] res;
        res = '0;
        for (int i = NOBJ - 1; i >= 0; i--) begin
            if (req[i]) begin
                res = {1'b1, IW'(i)};
            end
        end
        return res;
    endfunction

    // Register decode.
    assign page_ok = page_idx < IW'(NOBJ);
    assign wr_status = sfr_wr && page_ok && (sfr_addr == cms_pkg::ADDR_STATUS);
    assign wr_mask = sfr_wr && page_ok && (sfr_addr == cms_pkg::ADDR_MASK2);

    assign {tx_sel_valid, tx_sel_idx} = lowest(tx_enable & {NOBJ{tx_ready}});

    for (genvar g = 0; g < NOBJ; g++) begin : g_accept
        assign rx_hit[g] = rx_enable[g] && rx_high_match[g]
            && (((rx_id_low ^ obj_id_low[g*3 +: 3]) & mask_reg[g]) == 3'h0);
    end

    assign {rx_hit_valid, rx_hit_idx} = lowest(rx_hit);

    // Errors during transmission belong to the sending object, otherwise to the receiving one, or to the paged object if none accepts.
    assign err_obj = bus_bit.tx_active ? tx_obj_reg : (rx_hit_valid ? rx_hit_idx : page_idx);

    // Dominant acknowledge slot and error frame excluded.
    assign ev_bit_err = bus_bit.tick && bus_bit.tx_active
        && (bus_bit.rx_level != bus_bit.tx_level)
        && !(bus_bit.in_arb && bus_bit.tx_level && !bus_bit.rx_level)
        && !(bus_bit.in_ack && !bus_bit.rx_level)
        && !bus_bit.in_err_frame;

    assign ev_stuff_err = bus_bit.tick && bus_bit.stuff_region
        && (bus_bit.rx_level == last_level_reg) && (same_cnt_reg >= cms_pkg::STUFF_LIMIT);

    assign crc_fb = bus_bit.rx_level ^ crc_reg[14];
    assign crc_next = {crc_reg[13:0], 1'b0} ^ (crc_fb ? cms_pkg::CRC_POLY : 15'h0000);

    assign ev_crc_err = bus_field.crc_check && (crc_reg != crc_rx_reg);

    assign ev_form_err = bus_bit.tick && !bus_bit.rx_level
        && (bus_field.at_crc_delim || bus_field.at_ack_delim || bus_field.at_eof);

    // Missing acknowledge, judged at the acknowledge delimiter.
    assign ev_ack_err = bus_bit.tick && bus_bit.tx_active && bus_field.at_ack_delim && !ack_seen_reg;

    assign hit_dlc = obj_dlc[rx_hit_idx*4 +: 4];
    assign ev_len_warn = rx_done && rx_hit_valid && (rx_dlc != hit_dlc);

    assign err_set = (8'h01 << cms_pkg::BIT_BIT_ERR) & {8{ev_bit_err}}
        | (8'h01 << cms_pkg::BIT_STUFF_ERR) & {8{ev_stuff_err}}
        | (8'h01 << cms_pkg::BIT_CRC_ERR) & {8{ev_crc_err}}
        | (8'h01 << cms_pkg::BIT_FORM_ERR) & {8{ev_form_err}}
        | (8'h01 << cms_pkg::BIT_ACK_ERR) & {8{ev_ack_err}};

    // Per-object status; a hardware set in the cycle of a software write wins.
    for (genvar g = 0; g < NOBJ; g++) begin : g_obj
        logic [7:0] set_g;
        logic wr_g;
        assign wr_g = wr_status && (page_idx == IW'(g));
        assign set_g = ((err_obj == IW'(g)) ? err_set : 8'h00)
            | ((tx_done && tx_obj_reg == IW'(g)) ? (8'h01 << cms_pkg::BIT_TX_DONE) : 8'h00)
            | ((rx_done && rx_hit_valid && rx_hit_idx == IW'(g)) ? (8'h01 << cms_pkg::BIT_RX_DONE) : 8'h00)
            | ((ev_len_warn && rx_hit_idx == IW'(g)) ? (8'h01 << cms_pkg::BIT_LEN_WARN) : 8'h00);

        always_ff @(posedge clk) begin
            if (rst) begin
                status_reg[g] <= cms_pkg::STATUS_RST;
            end else begin
                status_reg[g] <= (wr_g ? sfr_wdata : status_reg[g]) | set_g;
            end
        end

        // Low bits of mask byte two are not stored.
        always_ff @(posedge clk) begin
            if (rst) begin
                mask_reg[g] <= cms_pkg::MASK_RST;
            end else if (wr_mask && page_idx == IW'(g)) begin
                mask_reg[g] <= sfr_wdata[cms_pkg::MASK_LSB +: cms_pkg::MASK_W];
            end
        end
    end

    // The transmit object is frozen at frame start so a late enable change cannot move its flags.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_obj_reg <= '0;
        end else if (tx_sel_valid && !bus_bit.tx_active) begin
            tx_obj_reg <= tx_sel_idx;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            same_cnt_reg <= 3'h0;
            last_level_reg <= 1'b1;
        end else if (bus_bit.tick) begin
            last_level_reg <= bus_bit.rx_level;
            if (!bus_bit.stuff_region || bus_bit.rx_level != last_level_reg) begin
                same_cnt_reg <= 3'h1;
            end else if (same_cnt_reg < cms_pkg::STUFF_LIMIT) begin
                same_cnt_reg <= same_cnt_reg + 3'h1;
            end
        end
    end

    // CRC accumulate and capture received field.
    always_ff @(posedge clk) begin
        if (rst || bus_field.crc_check) begin
            crc_reg <= cms_pkg::CRC_RST;
            crc_rx_reg <= cms_pkg::CRC_RST;
        end else if (bus_field.destuff_valid && bus_field.crc_calc) begin
            crc_reg <= crc_next;
        end else if (bus_field.destuff_valid && bus_field.crc_field) begin
            crc_rx_reg <= {crc_rx_reg[13:0], bus_bit.rx_level};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_seen_reg <= 1'b0;
        end else if (bus_bit.tick && bus_bit.in_ack) begin
            ack_seen_reg <= !bus_bit.rx_level;
        end
    end

    // Report lost arbitration instead of an error.
    always_ff @(posedge clk) begin
        if (rst) begin
            arb_lost_reg <= 1'b0;
        end else begin
            arb_lost_reg <= bus_bit.tick && bus_bit.tx_active && bus_bit.in_arb
                && bus_bit.tx_level && !bus_bit.rx_level;
        end
    end
    assign arb_lost = arb_lost_reg;

    // Read data is registered; reserved bits and unknown addresses read zero.
    always_ff @(posedge clk) begin
        if (rst || !page_ok) begin
            rdata_reg <= 8'h00;
        end else if (sfr_addr == cms_pkg::ADDR_STATUS) begin
            rdata_reg <= status_reg[page_idx];
        end else if (sfr_addr == cms_pkg::ADDR_MASK2) begin
            rdata_reg <= {mask_reg[page_idx], 5'h00};
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign sfr_rdata = rdata_reg;

endmodule

/* File: verilog/cms_pkg.sv */
package cms_pkg;

    // Register byte addresses in the special function register space.
    localparam logic [7:0] ADDR_STATUS = 8'hb2;
    localparam logic [7:0] ADDR_MASK2 = 8'hc5;
    localparam logic [7:0] ADDR_MASK3 = 8'hc6;

    // Field positions of the message object status register.
    localparam int BIT_LEN_WARN = 7;
    localparam int BIT_TX_DONE = 6;
    localparam int BIT_RX_DONE = 5;
    localparam int BIT_BIT_ERR = 4;
    localparam int BIT_STUFF_ERR = 3;
    localparam int BIT_CRC_ERR = 2;
    localparam int BIT_FORM_ERR = 1;
    localparam int BIT_ACK_ERR = 0;

    // Identifier mask low field sits in bits 7-5 of mask byte two.
    localparam int MASK_LSB = 5;
    localparam int MASK_W = 3;

    // Reset values of the stored state.
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [14:0] CRC_RST = 15'h0000;

    // Bus constants.
    localparam logic [14:0] CRC_POLY = 15'h4599;
    localparam logic [2:0] STUFF_LIMIT = 3'h5;
    localparam int NUM_OBJ = 14;
    localparam int IDX_W = 4;

    // Bit-level view of the bus, one sample per tick from the protocol engine.
    typedef struct packed {
        logic tick;         // Sample point of the current bit.
        logic rx_level;     // Level read back from the bus, 1 is recessive.
        logic tx_level;     // Level being driven, 1 is recessive.
        logic tx_active;    // Node is transmitter of the frame.
        logic in_arb;       // Bit belongs to the arbitration field.
        logic in_ack;       // Bit is the acknowledge slot.
        logic in_err_frame; // Node is sending an error frame.
        logic stuff_region; // Bit stuffing applies to this bit.
    } cms_bit_s;

    // Frame field markers for the CRC and form checks.
    typedef struct packed {
        logic destuff_valid; // A destuffed bit is present on rx_level.
        logic crc_calc;      // Destuffed bit lies in start of frame through data.
        logic crc_field;     // Destuffed bit lies in the received CRC field.
        logic crc_check;     // Pulse after the last CRC field bit.
        logic at_crc_delim;  // Bit is the CRC delimiter.
        logic at_ack_delim;  // Bit is the acknowledge delimiter.
        logic at_eof;        // Bit is inside end of frame.
    } cms_field_s;

endpackage
